// ===== hdl/ssf_top.sv
// Sample status flags, status alias and register read path of the sensor
//
// Functional notes
// (R1) FIFO mode 00: address 0x00 reads the sample status register at 0x06.
// (R2) FIFO mode nonzero: address 0x00 reads the FIFO status register at 0x0D.
// (R3) FIFO mode 00 off, 01 circular buffer, 10 full stop.
// (R4) Burst from 0x00 gives status first, then current data, or FIFO data with the FIFO on.
// (R5) Combined overwrite resets 0, sets when any unread result is overwritten.
// (R6) FIFO off: combined overwrite clears on pressure or temperature high byte read.
// (R7) FIFO on: reading the FIFO data port clears all six sample flags.
// (R8) Pressure overwrite resets 0, sets on unretrieved overwrite, clears on pressure read.
// (R9) Temperature overwrite resets 0, sets on unretrieved overwrite, clears on temp read.
// (R10) Combined ready resets 0, sets on any new result, clears on either high byte.
// (R11) Pressure ready sets on each pressure result, clears on pressure high byte read.
// (R12) Temperature ready sets on each temperature result, clears on temp high byte read.
// (R13) Pressure ready and overwrite generated only with pressure event enable set.
// (R14) Temperature ready and overwrite generated only with temperature event enable set.
// (R15) Combined ready and overwrite generated only with general ready enable set.
// (R16) A result arriving with its clearing read leaves the flag set.
`include "ssf_cfg.svh"

module ssf_top (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire ssf_pkg::ssf_rd_req_type   rd_req,
  input  wire ssf_pkg::ssf_sample_type   sample,
  input  wire ssf_pkg::ssf_event_cfg_type event_flag_config,
  input  wire ssf_pkg::ssf_fifo_mode_type fifo_mode,
  input  wire logic [7:0]                fifo_status,
  input  wire logic [7:0]                fifo_data,
  output logic      [7:0]                rd_data_q,
  output logic                           rd_valid_q,
  output logic                           fifo_pop_q,
  output logic      [7:0]                sample_status_reg
);
  import ssf_pkg::*;

  // ========================================================================
  // Helper functions

  // FIFO data driver enabled for any nonzero mode
  function automatic logic fifo_on_f(input ssf_fifo_mode_type mode);
    begin
      fifo_on_f = (mode != SSF_FIFO_OFF);                       // [R3]
    end
  endfunction : fifo_on_f

  // Read strobe aimed at one address
  function automatic logic hit_f(input logic en, input logic [7:0] a, input logic [7:0] t);
    begin
      hit_f = en && (a == t);
    end
  endfunction : hit_f

  // ========================================================================
  // Declarations
  logic [7:0]                  ptr_q;
  logic [7:0]                  ptr_d;
  logic [7:0]                  rd_addr;
  logic [7:0]                  next_addr;
  logic                        fifo_on;
  logic                        circular_mode;
  logic                        stop_mode;
  logic                        p_high_rd;
  logic                        t_high_rd;
  logic                        fdata_rd;
  logic                        p_clr;
  logic                        t_clr;
  logic                        all_clr;
  logic                        p_ovw;
  logic                        t_ovw;
  logic [`SSF_FLG_COUNT-1:0]   flag_set;
  logic [`SSF_FLG_COUNT-1:0]   flag_clr;
  logic [`SSF_FLG_COUNT-1:0]   flag_q;
  logic [7:0]                  status_byte;
  logic [7:0]                  rd_data_d;

  // ========================================================================
  // Mode decode
  assign fifo_on       = fifo_on_f(fifo_mode);                  // [R3]
  assign circular_mode = (fifo_mode == SSF_FIFO_CIRCULAR);      // [R3]
  assign stop_mode     = (fifo_mode == SSF_FIFO_STOP);          // [R3]

  // ========================================================================
  // Burst address: start address or the auto-incremented pointer
  assign rd_addr = rd_req.start ? rd_req.addr : ptr_q;          // [R4]

  ssf_addr_step u_addr_step (
    .cur_addr  (rd_addr),
    .fifo_on   (fifo_on),
    .next_addr (next_addr)
  );

  // Pointer advances on each read of a burst
  always_comb
  begin
    ptr_d = ptr_q;
    if (rd_req.en)
      ptr_d = next_addr;                                        // [R4]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ptr_q <= `SSF_ADDR_STATUS_ALIAS;
    else
      ptr_q <= ptr_d;
  end

  // ========================================================================
  // Clearing reads
  assign p_high_rd = hit_f(rd_req.en, rd_addr, `SSF_ADDR_P_HIGH) && !fifo_on;
  assign t_high_rd = hit_f(rd_req.en, rd_addr, `SSF_ADDR_T_HIGH) && !fifo_on;
  assign fdata_rd  = hit_f(rd_req.en, rd_addr, `SSF_ADDR_FIFO_DATA) && fifo_on;

  // Per-channel clears; FIFO data read clears everything
  assign all_clr = fdata_rd;                                    // [R7]
  assign p_clr   = p_high_rd || all_clr;                        // [R8] [R11]
  assign t_clr   = t_high_rd || all_clr;                        // [R9] [R12]

  // ========================================================================
  // Overwrite detection against results not yet retrieved
  assign p_ovw = sample.p_done && flag_q[`SSF_FLG_PUNRD];
  assign t_ovw = sample.t_done && flag_q[`SSF_FLG_TUNRD];

  // ========================================================================
  // Set and clear terms of every flag
  always_comb
  begin
    flag_set = '0;
    flag_clr = '0;
    // Unread trackers follow each result regardless of enables
    flag_set[`SSF_FLG_PUNRD] = sample.p_done;
    flag_set[`SSF_FLG_TUNRD] = sample.t_done;
    flag_clr[`SSF_FLG_PUNRD] = p_clr;
    flag_clr[`SSF_FLG_TUNRD] = t_clr;
    // Pressure ready and overwrite
    flag_set[`SSF_FLG_P_RDY] = sample.p_done
                             && event_flag_config.pressure_event_enable;     // [R11] [R13]
    flag_set[`SSF_FLG_P_OVW] = p_ovw
                             && event_flag_config.pressure_event_enable;     // [R8] [R13]
    flag_clr[`SSF_FLG_P_RDY] = p_clr;                                        // [R11]
    flag_clr[`SSF_FLG_P_OVW] = p_clr;                                        // [R8]
    // Temperature ready and overwrite
    flag_set[`SSF_FLG_T_RDY] = sample.t_done
                             && event_flag_config.temperature_event_enable;  // [R12] [R14]
    flag_set[`SSF_FLG_T_OVW] = t_ovw
                             && event_flag_config.temperature_event_enable;  // [R9] [R14]
    flag_clr[`SSF_FLG_T_RDY] = t_clr;                                        // [R12]
    flag_clr[`SSF_FLG_T_OVW] = t_clr;                                        // [R9]
    // Combined ready and overwrite
    flag_set[`SSF_FLG_C_RDY] = (sample.p_done || sample.t_done)
                             && event_flag_config.general_ready_event_enable; // [R10] [R15]
    flag_set[`SSF_FLG_C_OVW] = (p_ovw || t_ovw)
                             && event_flag_config.general_ready_event_enable; // [R5] [R15]
    flag_clr[`SSF_FLG_C_RDY] = p_high_rd || t_high_rd || all_clr;            // [R10] [R7]
    flag_clr[`SSF_FLG_C_OVW] = p_high_rd || t_high_rd || all_clr;            // [R6] [R7]
  end

  // ========================================================================
  // Flag storage, set wins over clear
  generate
    for (genvar i = 0; i < `SSF_FLG_COUNT; i++)
    begin : g_flag
      ssf_flag_cell u_cell (
        .clk    (clk),
        .rst    (rst),
        .set    (flag_set[i]),                                  // [R16]
        .clr    (flag_clr[i]),
        .flag_q (flag_q[i])
      );
    end
  endgenerate

  // ========================================================================
  // Sample status byte layout
  assign status_byte = {flag_q[`SSF_FLG_C_OVW], flag_q[`SSF_FLG_T_OVW],
                        flag_q[`SSF_FLG_P_OVW], `SSF_BIT_ZERO,
                        flag_q[`SSF_FLG_C_RDY], flag_q[`SSF_FLG_T_RDY],
                        flag_q[`SSF_FLG_P_RDY], `SSF_BIT_ZERO};
  assign sample_status_reg = status_byte;                       // Wired from flag flops

  // ========================================================================
  // Read data selection; reserved words read zero in FIFO mode
  always_comb
  begin
    rd_data_d = `SSF_BYTE_ZERO;
    unique case (rd_addr)
      `SSF_ADDR_STATUS_ALIAS:
        rd_data_d = fifo_on ? fifo_status : status_byte;        // [R1] [R2]
      `SSF_ADDR_P_HIGH:
        rd_data_d = fifo_on ? fifo_data : sample.p_data[`SSF_P_HI];
      `SSF_ADDR_P_MID:
        rd_data_d = fifo_on ? `SSF_BYTE_ZERO : sample.p_data[`SSF_P_MID];
      `SSF_ADDR_P_LOW:
        rd_data_d = fifo_on ? `SSF_BYTE_ZERO : {sample.p_data[`SSF_P_LO], `SSF_NIBBLE_ZERO};
      `SSF_ADDR_T_HIGH:
        rd_data_d = fifo_on ? `SSF_BYTE_ZERO : sample.t_data[`SSF_T_HI];
      `SSF_ADDR_T_LOW:
        rd_data_d = fifo_on ? `SSF_BYTE_ZERO : {sample.t_data[`SSF_T_LO], `SSF_NIBBLE_ZERO};
      `SSF_ADDR_SAMPLE_STATUS:
        rd_data_d = status_byte;                                // [R1]
      `SSF_ADDR_PD_HIGH:
        rd_data_d = sample.p_delta[`SSF_P_HI];                  // [R4]
      `SSF_ADDR_PD_MID:
        rd_data_d = sample.p_delta[`SSF_P_MID];
      `SSF_ADDR_PD_LOW:
        rd_data_d = {sample.p_delta[`SSF_P_LO], `SSF_NIBBLE_ZERO};
      `SSF_ADDR_TD_HIGH:
        rd_data_d = sample.t_delta[`SSF_T_HI];
      `SSF_ADDR_TD_LOW:
        rd_data_d = {sample.t_delta[`SSF_T_LO], `SSF_NIBBLE_ZERO};
      `SSF_ADDR_FIFO_STATUS:
        rd_data_d = fifo_status;                                // [R2]
      default:
        rd_data_d = `SSF_BYTE_ZERO;
    endcase
  end

  // ========================================================================
  // Read answer register, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_data_q  <= `SSF_BYTE_ZERO;
      rd_valid_q <= `SSF_FLAG_RESET;
    end
    else
    begin
      rd_valid_q <= rd_req.en;
      if (rd_req.en)
        rd_data_q <= rd_data_d;
    end
  end

  // ========================================================================
  // FIFO pop strobe on each FIFO data read in circular or full stop mode
  always_ff @(posedge clk)
  begin
    if (rst)
      fifo_pop_q <= `SSF_FLAG_RESET;
    else
      fifo_pop_q <= fdata_rd && (circular_mode || stop_mode);   // [R7]
  end

endmodule : ssf_top

// ===== common/ssf_cfg.svh
// Address map, field positions and reset values of the sample status flag block
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH

// ==========================================================================
// Register addresses
`define SSF_ADDR_STATUS_ALIAS  8'h00
`define SSF_ADDR_P_HIGH        8'h01
`define SSF_ADDR_P_MID         8'h02
`define SSF_ADDR_P_LOW         8'h03
`define SSF_ADDR_T_HIGH        8'h04
`define SSF_ADDR_T_LOW         8'h05
`define SSF_ADDR_SAMPLE_STATUS 8'h06
`define SSF_ADDR_PD_HIGH       8'h07
`define SSF_ADDR_PD_MID        8'h08
`define SSF_ADDR_PD_LOW        8'h09
`define SSF_ADDR_TD_HIGH       8'h0A
`define SSF_ADDR_TD_LOW        8'h0B
`define SSF_ADDR_FIFO_STATUS   8'h0D
`define SSF_ADDR_FIFO_DATA     8'h01
`define SSF_ADDR_ONE           8'h01

// ==========================================================================
// Flag vector indices
`define SSF_FLG_P_RDY 0
`define SSF_FLG_T_RDY 1
`define SSF_FLG_C_RDY 2
`define SSF_FLG_P_OVW 3
`define SSF_FLG_T_OVW 4
`define SSF_FLG_C_OVW 5
`define SSF_FLG_PUNRD 6
`define SSF_FLG_TUNRD 7
`define SSF_FLG_COUNT 8

// ==========================================================================
// Bit ranges of the result bytes
`define SSF_P_HI  19:12
`define SSF_P_MID 11:4
`define SSF_P_LO  3:0
`define SSF_T_HI  11:4
`define SSF_T_LO  3:0

// ==========================================================================
// Reset values and fillers
`define SSF_FLAG_RESET 1'b0
`define SSF_BYTE_ZERO  8'h00
`define SSF_NIBBLE_ZERO 4'h0
`define SSF_BIT_ZERO   1'b0

`endif

// ===== common/ssf_pkg.sv
// Types shared by the sample status flag block
package ssf_pkg;

  // ========================================================================
  // FIFO mode field encodings
  typedef enum logic [1:0] {
    SSF_FIFO_OFF      = 2'h0,
    SSF_FIFO_CIRCULAR = 2'h1,
    SSF_FIFO_STOP     = 2'h2,
    SSF_FIFO_RSVD     = 2'h3
  } ssf_fifo_mode_type;

  // ========================================================================
  // Register read request from the serial engine
  typedef struct packed {
    logic       en;
    logic       start;
    logic [7:0] addr;
  } ssf_rd_req_type;

  // Acquisition results and completion strobes
  typedef struct packed {
    logic        p_done;
    logic        t_done;
    logic [19:0] p_data;
    logic [11:0] t_data;
    logic [19:0] p_delta;
    logic [11:0] t_delta;
  } ssf_sample_type;

  // Event flag configuration bits
  typedef struct packed {
    logic pressure_event_enable;
    logic temperature_event_enable;
    logic general_ready_event_enable;
  } ssf_event_cfg_type;

endpackage : ssf_pkg

// ===== hdl/ssf_flag_cell.sv
// Sticky flag whose set wins over a clear in the same cycle
`include "ssf_cfg.svh"

module ssf_flag_cell (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_q
);
  // ========================================================================
  // Flag storage
  always_ff @(posedge clk)
  begin
    if (rst)
      flag_q <= `SSF_FLAG_RESET;
    else if (set)
      flag_q <= 1'b1;            // New event is never lost
    else if (clr)
      flag_q <= `SSF_FLAG_RESET;
  end
endmodule : ssf_flag_cell

// ===== hdl/ssf_addr_step.sv
// Next address of an auto-incrementing register burst
`include "ssf_cfg.svh"

module ssf_addr_step (
  input  wire logic [7:0] cur_addr,
  input  wire logic       fifo_on,
  output logic      [7:0] next_addr
);
  // ========================================================================
  // Wrap points of the status and data area
  always_comb
  begin
    unique case (cur_addr)
      `SSF_ADDR_STATUS_ALIAS:  next_addr = `SSF_ADDR_ONE;
      `SSF_ADDR_FIFO_DATA:     next_addr = fifo_on ? `SSF_ADDR_FIFO_DATA : `SSF_ADDR_P_MID;
      `SSF_ADDR_T_LOW:         next_addr = `SSF_ADDR_STATUS_ALIAS;
      `SSF_ADDR_SAMPLE_STATUS: next_addr = `SSF_ADDR_ONE;
      `SSF_ADDR_FIFO_STATUS:   next_addr = `SSF_ADDR_ONE;
      default:                 next_addr = cur_addr + `SSF_ADDR_ONE;
    endcase
  end
endmodule : ssf_addr_step

// ===== tb/ssf_host_model.sv
// Host read engine model: issues register reads and collects the answers
module ssf_host_model
  import ssf_pkg::*;
(
  input  wire logic                    clk,
  input  wire ssf_pkg::ssf_rd_req_type cmd,
  input  wire logic                    rd_valid_q,
  input  wire logic [7:0]              rd_data_q,
  output ssf_pkg::ssf_rd_req_type      rd_req
);
  logic [7:0] got[$];

  // ====================
  // Request launch, address scrambled while idle so a stale value never helps
  always @(posedge clk)
  begin
    rd_req <= cmd.en ? cmd : ssf_rd_req_type'{en: 1'b0, start: cmd.start, addr: ~cmd.addr};
  end

  // Answer capture, one byte per valid pulse
  always @(posedge clk)
  begin
    if (rd_valid_q)
      got.push_back(rd_data_q);
  end
endmodule : ssf_host_model

// ===== tb/ssf_top_asserts.sv
// Port checker of the sample status flag block
module ssf_top_asserts
  import ssf_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst,
  input wire ssf_pkg::ssf_rd_req_type     rd_req,
  input wire ssf_pkg::ssf_sample_type     sample,
  input wire ssf_pkg::ssf_event_cfg_type  event_flag_config,
  input wire ssf_pkg::ssf_fifo_mode_type  fifo_mode,
  input wire logic [7:0]                  fifo_status,
  input wire logic [7:0]                  rd_data_q,
  input wire logic                        rd_valid_q,
  input wire logic                        fifo_pop_q,
  input wire logic [7:0]                  sample_status_reg
);
  wire pe = event_flag_config.pressure_event_enable;
  wire te = event_flag_config.temperature_event_enable;
  wire ge = event_flag_config.general_ready_event_enable;
  wire pd = sample.p_done;
  wire td = sample.t_done;
  wire off = (fifo_mode == SSF_FIFO_OFF);

  // ====================
  // Clocking and read sequences
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_rd(logic [7:0] a);
    rd_req.en && rd_req.start && rd_req.addr == a;
  endsequence
  sequence s_burst;
    s_rd(8'h00) ##1 (rd_req.en && !rd_req.start && off);
  endsequence

  // ====================
  // Properties
  property p_p_set; pd && pe |=> sample_status_reg[1]; endproperty
  property p_t_set; td && te |=> sample_status_reg[2]; endproperty
  property p_c_set; (pd || td) && ge |=> sample_status_reg[3]; endproperty
  property p_p_gate; $rose(sample_status_reg[1]) |-> $past(pd && pe); endproperty
  property p_c_gate; $rose(sample_status_reg[3]) |-> $past((pd || td) && ge); endproperty
  property p_t_gate; $rose(sample_status_reg[2]) |-> $past(td && te); endproperty
  property p_p_ow; $rose(sample_status_reg[5]) |-> $past(pd && pe); endproperty
  property p_t_ow; $rose(sample_status_reg[6]) |-> $past(td && te); endproperty
  property p_ow_src; $rose(sample_status_reg[7]) |-> $past((pd || td) && ge); endproperty
  property p_p_clr;
    s_rd(8'h01) ##0 (off && !pd && !td) |=> (sample_status_reg & 8'hAA) == 8'h00;
  endproperty
  property p_t_clr;
    s_rd(8'h04) ##0 (off && !pd && !td) |=> (sample_status_reg & 8'hCC) == 8'h00;
  endproperty
  property p_f_clr;
    s_rd(8'h01) ##0 (!off && !pd && !td) |=> sample_status_reg == 8'h00
      && fifo_pop_q == ($past(fifo_mode) != SSF_FIFO_RSVD);
  endproperty
  property p_alias;
    s_rd(8'h00) |=> rd_valid_q && rd_data_q ==
      ($past(off) ? $past(sample_status_reg) : $past(fifo_status));
  endproperty
  property p_burst; s_burst |=> rd_data_q == $past(sample.p_data[19:12]); endproperty

  // ====================
  // Assertions
  a_p_set: assert property (p_p_set) else $error("pressure ready not set");
  a_t_set: assert property (p_t_set) else $error("temperature ready not set");
  a_c_set: assert property (p_c_set) else $error("combined ready not set");
  a_p_gate: assert property (p_p_gate) else $error("pressure ready without cause");
  a_c_gate: assert property (p_c_gate) else $error("combined ready without cause");
  a_t_gate: assert property (p_t_gate) else $error("temp ready without cause");
  a_p_ow: assert property (p_p_ow) else $error("pressure overwrite without sample");
  a_t_ow: assert property (p_t_ow) else $error("temp overwrite without sample");
  a_ow_src: assert property (p_ow_src) else $error("overwrite without sample");
  a_p_clr: assert property (p_p_clr) else $error("pressure read left flags");
  a_t_clr: assert property (p_t_clr) else $error("temperature read left flags");
  a_f_clr: assert property (p_f_clr) else $error("fifo read left flags");
  a_alias: assert property (p_alias) else $error("status alias wrong");
  a_burst: assert property (p_burst) else $error("burst second byte wrong");
endmodule : ssf_top_asserts

bind ssf_top ssf_top_asserts ssf_top_asserts_inst (
  .clk(clk), .rst(rst), .rd_req(rd_req), .sample(sample),
  .event_flag_config(event_flag_config), .fifo_mode(fifo_mode),
  .fifo_status(fifo_status), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
  .fifo_pop_q(fifo_pop_q), .sample_status_reg(sample_status_reg)
);

// ===== tb/tb_ssf_top.sv
// Self-checking bench of the sample status flag block
module tb_ssf_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ssf_pkg::*;
  logic              clk, rst, rd_valid_q, fifo_pop_q;
  ssf_rd_req_type    cmd, rd_req;
  ssf_sample_type    smp;
  ssf_event_cfg_type ecfg;
  ssf_fifo_mode_type fmode;
  logic [7:0]        fstat, fdata, rd_data_q, sample_status_reg;
  int                error_cnt, checked;
  int                pop_cnt;

  // ====================
  // Design and host model
  ssf_top ssf_top_inst (.clk(clk), .rst(rst), .rd_req(rd_req), .sample(smp),
    .event_flag_config(ecfg), .fifo_mode(fmode), .fifo_status(fstat), .fifo_data(fdata),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .fifo_pop_q(fifo_pop_q),
    .sample_status_reg(sample_status_reg));
  ssf_host_model ssf_host_model_inst (.clk(clk), .cmd(cmd), .rd_valid_q(rd_valid_q),
    .rd_data_q(rd_data_q), .rd_req(rd_req));

  // FIFO pop counter
  always @(posedge clk)
  begin
    if (fifo_pop_q)
      pop_cnt++;
  end

  // Clock, 40 ns period
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ====================
  // Shared tasks
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rd(input logic st, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) cmd <= '{en: 1'b1, start: st, addr: a};
    @(posedge clk) cmd.en <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("read", exp, ssf_host_model_inst.got.pop_front());
  endtask : rd

  task automatic pulse(input logic p, input logic t);
    @(posedge clk)
    begin
      smp.p_done <= p;
      smp.t_done <= t;
    end
    @(posedge clk)
    begin
      smp.p_done <= 1'b0;
      smp.t_done <= 1'b0;
    end
    @(posedge clk) #1;
  endtask : pulse

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // ====================
  // Scenarios
  task automatic t_flags;
    pulse(1'b1, 1'b0);
    chk("status", 8'h0A, sample_status_reg);
    rd(1'b1, 8'h00, 8'h0A);
    rd(1'b1, 8'h06, 8'h0A);
    pulse(1'b1, 1'b0);
    chk("status", 8'hAA, sample_status_reg);
    pulse(1'b0, 1'b1);
    pulse(1'b0, 1'b1);
    chk("status", 8'hEE, sample_status_reg);
    rd(1'b1, 8'h07, 8'h12);
    rd(1'b1, 8'h0B, 8'h80);
    rd(1'b1, 8'h0D, 8'h5A);
    $display("test flags done");
  endtask : t_flags

  task automatic t_burst;
    logic [7:0] ex[6];
    ex = '{8'hEE, 8'hAB, 8'hCD, 8'hE0, 8'h9F, 8'h30};
    for (int i = 0; i < 6; i++)
      @(posedge clk) cmd <= '{en: 1'b1, start: (i == 0), addr: 8'h00};
    @(posedge clk) cmd.en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    foreach (ex[i]) chk("burst", ex[i], ssf_host_model_inst.got.pop_front());
    chk("status", 8'h00, sample_status_reg);
    $display("test burst done");
  endtask : t_burst

  task automatic t_race;
    @(posedge clk) cmd <= '{en: 1'b1, start: 1'b1, addr: 8'h01};
    @(posedge clk)
    begin
      cmd.en <= 1'b0;
      smp.p_done <= 1'b1;
    end
    @(posedge clk) smp.p_done <= 1'b0;
    repeat (2) @(posedge clk);
    #1 void'(ssf_host_model_inst.got.pop_front());
    chk("status", 8'h0A, sample_status_reg);
    rd(1'b1, 8'h01, 8'hAB);
    chk("status", 8'h00, sample_status_reg);
    $display("test race done");
  endtask : t_race

  task automatic t_gate;
    @(posedge clk) ecfg <= 3'b000;
    pulse(1'b1, 1'b1);
    chk("status", 8'h00, sample_status_reg);
    rd(1'b1, 8'h01, 8'hAB);
    rd(1'b1, 8'h04, 8'h9F);
    @(posedge clk) ecfg <= 3'b100;
    pulse(1'b1, 1'b0);
    chk("status", 8'h02, sample_status_reg);
    @(posedge clk) ecfg <= 3'b011;
    pulse(1'b0, 1'b1);
    chk("status", 8'h0E, sample_status_reg);
    @(posedge clk) ecfg <= 3'b111;
    rd(1'b1, 8'h01, 8'hAB);
    rd(1'b1, 8'h04, 8'h9F);
    chk("status", 8'h00, sample_status_reg);
    $display("test gate done");
  endtask : t_gate

  task automatic t_fifo;
    for (int m = 1; m < 4; m++)
    begin
      @(posedge clk) fmode <= ssf_fifo_mode_type'(m);
      pulse(1'b1, 1'b1);
      pulse(1'b1, 1'b1);
      chk("status", 8'hEE, sample_status_reg);
      rd(1'b1, 8'h00, fstat);
      rd(1'b1, 8'h03, 8'h00);
      rd(1'b1, 8'h01, fdata);
      chk("pops", 8'((m < 3) ? m : 2), 8'(pop_cnt));
      chk("status", 8'h00, sample_status_reg);
    end
    @(posedge clk) fmode <= SSF_FIFO_OFF;
    $display("test fifo done");
  endtask : t_fifo

  task automatic t_reset;
    pulse(1'b1, 1'b1);
    pulse(1'b1, 1'b1);
    chk("status", 8'hEE, sample_status_reg);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    chk("status", 8'h00, sample_status_reg);
    pulse(1'b1, 1'b0);
    chk("status", 8'h0A, sample_status_reg);
    $display("test reset done");
  endtask : t_reset

  // ====================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    cmd = '0;
    smp = '0;
    smp.p_data = 20'hABCDE;
    smp.t_data = 12'h9F3;
    smp.p_delta = 20'h12345;
    smp.t_delta = 12'h678;
    ecfg = 3'b111;
    fmode = SSF_FIFO_OFF;
    fstat = 8'h5A;
    fdata = 8'hC3;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    chk("status", 8'h00, sample_status_reg);
    chk("valid", 8'h00, {7'h00, rd_valid_q});
    t_flags();
    t_burst();
    t_race();
    t_gate();
    t_fifo();
    t_reset();
    wrap_up();
  end

  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    $display("mismatch watchdog expected end seen timeout");
    wrap_up();
  end
endmodule : tb_ssf_top
